// ---- shared/eirq_cfg.svh ----
// Operation
// - Seventeen one-word vectors, addresses 0x0000 to 0x0010
// - Every reset cause dispatches address 0x0000
// - External pin request dispatches address 0x0001
// - Pin-change groups dispatch 0x0002 and 0x0003
// - Watchdog 0x0004, 16-bit timer 0x0005-0x0008
// - 8-bit timer, comparator, converter, EEPROM, serial follow
// - No enabled source, no vector fetch
// - Pins trigger even when driven as outputs
// - Lower request on masked toggle of inputs 7:0
// - Upper request on masked toggle of inputs 11:8
// - Per-pin masks select contributing pin-change inputs
// - Pin-change detection works without I/O clock
// - External pin senses falling, rising or low
// - Low level requests continuously while pin low
// - Edge detection needs running I/O clock
// - Low-level detection is asynchronous, wakes any sleep
// - Level gone before wake: no service routine
// - Sense codes: 00 low, 01 change, 10 fall, 11 rise
// - Pin sampled before edge detection
// - External flag sets on edge, clears, zero in level
// - Requests need own enable and global enable; reset request is ungated, peripheral requests are gated by global enable only
`ifndef EIRQ_CFG_SVH
`define EIRQ_CFG_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define EIRQ_ADR_CTRL     8'h00
`define EIRQ_ADR_FLAG     8'h04
`define EIRQ_ADR_MASK_LO  8'h08
`define EIRQ_ADR_MASK_HI  8'h0C
`define EIRQ_ADR_STATUS   8'h10

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define EIRQ_FLG_EXT      0
`define EIRQ_FLG_PCL      1
`define EIRQ_FLG_PCH      2
`define EIRQ_ST_VALID     5
`define EIRQ_ST_PIN       6
`define EIRQ_ST_WAKE      7
`define EIRQ_CTRL_RST     5'h00
`define EIRQ_MASK_RST     8'h00

// ----------------------------------------
// Sense select codes
// ----------------------------------------
`define EIRQ_SENSE_LOW    2'h0
`define EIRQ_SENSE_ANY    2'h1
`define EIRQ_SENSE_FALL   2'h2
`define EIRQ_SENSE_RISE   2'h3

// ----------------------------------------
// Vector addresses
// ----------------------------------------
`define EIRQ_VEC_RESET    5'h00
`define EIRQ_VEC_EXT      5'h01
`define EIRQ_VEC_PCL      5'h02
`define EIRQ_VEC_PCH      5'h03
`define EIRQ_VEC_PERIPH   5'h04
`define EIRQ_VEC_LAST     5'h10
`define EIRQ_VEC_COUNT    17
`define EIRQ_PERIPH_COUNT 13

`endif

// ---- shared/eirq_pkg.sv ----
package eirq_pkg;

    typedef struct packed {
        logic       pcHighEn;
        logic       pcLowEn;
        logic       extEn;
        logic [1:0] sense;
    } eirq_ctrl_t;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } eirq_wbreq_t;

endpackage : eirq_pkg

// ---- design/eirq_pc_group.sv ----
`timescale 1ns/1ps
module eirq_pc_group #(
    parameter int W = 8
) (
    input  wire logic         mclk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] pins,
    input  wire logic [W-1:0] mask,
    input  wire logic         clr,
    output logic              change,
    output logic              flag
);
    generate
        if (W < 1) begin : g_bad_w
            $error("pin-change group needs at least one input");
        end
    endgenerate

    logic [W-1:0] ref_q;
    logic [W-1:0] ref_d;
    logic         flag_q;
    logic         flag_d;

    // Live compare, needs no I/O clock
    assign change = |((pins ^ ref_q) & mask);
    assign flag   = flag_q;

    always_comb begin
        ref_d  = pins;
        flag_d = change | (flag_q & ~clr);
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ref_q  <= '0;
            flag_q <= 1'b0;
        end else begin
            ref_q  <= ref_d;
            flag_q <= flag_d;
        end
    end
endmodule : eirq_pc_group

// ---- design/eirq_prio.sv ----
`timescale 1ns/1ps
module eirq_prio #(
    parameter int N = 17
) (
    input  wire logic [N-1:0] req,
    output logic [4:0]        idx,
    output logic              valid
);
    // Index output is five bits wide
    generate
        if (N < 1 || N > 32) begin : g_bad_n
            $error("request count must lie between 1 and 32");
        end
    endgenerate

    function automatic logic [4:0] lowestSet(input logic [N-1:0] r);
        logic [4:0] k;
        k = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (r[i]) begin
                k = 5'(i);
            end
        end
        return k;
    endfunction : lowestSet

    assign idx   = lowestSet(req);
    assign valid = |req;
endmodule : eirq_prio

// ---- design/eirq_top.sv ----
`timescale 1ns/1ps
`include "eirq_cfg.svh"
module eirq_top #(
    parameter int PC_LOW_W  = 8,
    parameter int PC_HIGH_W = 4,
    parameter int N_PERIPH  = `EIRQ_PERIPH_COUNT
) (
    input  wire logic                mclk,
    input  wire logic                rst_n,
    input  wire logic                wb_cyc_i,
    input  wire logic                wb_stb_i,
    input  wire logic                wb_we_i,
    input  wire logic [7:0]          wb_adr_i,
    input  wire logic [3:0]          wb_sel_i,
    input  wire logic [31:0]         wb_dat_i,
    output logic      [31:0]         wb_dat_o,
    output logic                     wb_ack_o,
    input  wire logic                extIrqPin,
    input  wire logic [11:0]         pinChangeInputs,
    input  wire logic                ioClkEn,
    input  wire logic                globalIntEn,
    input  wire logic [3:0]          resetCause,
    input  wire logic [N_PERIPH-1:0] periphReq,
    input  wire logic                vecTaken,
    output logic                     vecValid,
    output logic      [4:0]          vecAddr,
    output logic      [N_PERIPH-1:0] periphAck,
    output logic                     wakeReq
);
    localparam int NVEC = 4 + N_PERIPH;

    // ----------------------------------------
    // Elaboration checks
    // ----------------------------------------
    generate
        if (PC_LOW_W < 1 || PC_LOW_W > 8) begin : g_bad_low
            $error("pin-change low group width out of range");
        end
        if (PC_HIGH_W < 1 || PC_HIGH_W > 8) begin : g_bad_high
            $error("pin-change high group width out of range");
        end
        if (PC_LOW_W + PC_HIGH_W != 12) begin : g_bad_pins
            $error("pin-change groups must cover twelve inputs");
        end
        if (NVEC != `EIRQ_VEC_COUNT) begin : g_bad_vec
            $error("vector table must hold seventeen entries");
        end
    endgenerate

    // ----------------------------------------
    // Bus request and decode
    // ----------------------------------------
    eirq_pkg::eirq_wbreq_t wbReq;
    logic                  ack_q;
    logic                  ack_d;
    logic                  busHit;
    logic                  busWr;
    logic [31:0]           rdat_q;
    logic [31:0]           rdat_d;

    function automatic logic regHit(input logic [7:0] adr, input logic [7:0] off);
        return adr == off;
    endfunction : regHit

    assign wbReq = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i,
                     adr: wb_adr_i, sel: wb_sel_i, dat: wb_dat_i};
    assign busHit = wbReq.cyc & wbReq.stb & ~ack_q;
    assign busWr  = busHit & wbReq.we & wbReq.sel[0];
    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;

    // ----------------------------------------
    // Control, mask and flag-clear writes
    // ----------------------------------------
    eirq_pkg::eirq_ctrl_t   ctrl_q;
    eirq_pkg::eirq_ctrl_t   ctrl_d;
    logic [7:0]             maskLo_q;
    logic [7:0]             maskLo_d;
    logic [7:0]             maskHi_q;
    logic [7:0]             maskHi_d;
    logic                   wrFlag;

    assign wrFlag = busWr & regHit(wbReq.adr, `EIRQ_ADR_FLAG);

    always_comb begin
        ctrl_d   = ctrl_q;
        maskLo_d = maskLo_q;
        maskHi_d = maskHi_q;
        if (busWr && regHit(wbReq.adr, `EIRQ_ADR_CTRL)) begin
            ctrl_d = eirq_pkg::eirq_ctrl_t'(wbReq.dat[4:0]);
        end
        if (busWr && regHit(wbReq.adr, `EIRQ_ADR_MASK_LO)) begin
            maskLo_d = wbReq.dat[7:0];
        end
        if (busWr && regHit(wbReq.adr, `EIRQ_ADR_MASK_HI)) begin
            maskHi_d = wbReq.dat[7:0];
        end
        // Bits above the group width read as zero
        maskLo_d = maskLo_d & 8'((9'h001 << PC_LOW_W) - 9'h001);
        maskHi_d = maskHi_d & 8'((9'h001 << PC_HIGH_W) - 9'h001);
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q   <= `EIRQ_CTRL_RST;
            maskLo_q <= `EIRQ_MASK_RST;
            maskHi_q <= `EIRQ_MASK_RST;
        end else begin
            ctrl_q   <= ctrl_d;
            maskLo_q <= maskLo_d;
            maskHi_q <= maskHi_d;
        end
    end

    // ----------------------------------------
    // External pin sampling and edge detect
    // ----------------------------------------
    logic pinSamp_q;
    logic pinSamp_d;
    logic pinPrev_q;
    logic pinPrev_d;
    logic extFlag_q;
    logic extFlag_d;
    logic levelMode;
    logic edgeHit;
    logic extReq;
    logic takeExt;

    // Pad level is read regardless of pin direction
    assign levelMode = ctrl_q.sense == `EIRQ_SENSE_LOW;

    always_comb begin
        pinSamp_d = pinSamp_q;
        pinPrev_d = pinPrev_q;
        // Sampler only advances on the I/O clock
        if (ioClkEn) begin
            pinSamp_d = extIrqPin;
            pinPrev_d = pinSamp_q;
        end
    end

    always_comb begin
        unique case (ctrl_q.sense)
            `EIRQ_SENSE_ANY:  edgeHit = pinSamp_q ^ pinPrev_q;
            `EIRQ_SENSE_FALL: edgeHit = ~pinSamp_q & pinPrev_q;
            `EIRQ_SENSE_RISE: edgeHit = pinSamp_q & ~pinPrev_q;
            `EIRQ_SENSE_LOW:  edgeHit = 1'b0;
        endcase
        edgeHit = edgeHit & ioClkEn;
    end

    assign takeExt = vecTaken & vecValid & (vecAddr == `EIRQ_VEC_EXT);

    always_comb begin
        extFlag_d = edgeHit
                  | (extFlag_q & ~takeExt
                     & ~(wrFlag & wbReq.dat[`EIRQ_FLG_EXT]));
        if (levelMode) begin
            extFlag_d = 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pinSamp_q <= 1'b1;
            pinPrev_q <= 1'b1;
            extFlag_q <= 1'b0;
        end else begin
            pinSamp_q <= pinSamp_d;
            pinPrev_q <= pinPrev_d;
            extFlag_q <= extFlag_d;
        end
    end

    // Level request follows the live pin, no flag kept
    assign extReq = levelMode ? ~extIrqPin : extFlag_q;

    // ----------------------------------------
    // Pin-change groups
    // ----------------------------------------
    logic pclChange;
    logic pchChange;
    logic pclFlag;
    logic pchFlag;
    logic takePcl;
    logic takePch;

    assign takePcl = (vecTaken & vecValid & (vecAddr == `EIRQ_VEC_PCL))
                   | (wrFlag & wbReq.dat[`EIRQ_FLG_PCL]);
    assign takePch = (vecTaken & vecValid & (vecAddr == `EIRQ_VEC_PCH))
                   | (wrFlag & wbReq.dat[`EIRQ_FLG_PCH]);

    eirq_pc_group #(
        .W (PC_LOW_W)
    ) u_pcl (
        .mclk   (mclk),
        .rst_n  (rst_n),
        .pins   (pinChangeInputs[PC_LOW_W-1:0]),
        .mask   (maskLo_q[PC_LOW_W-1:0]),
        .clr    (takePcl),
        .change (pclChange),
        .flag   (pclFlag)
    );

    eirq_pc_group #(
        .W (PC_HIGH_W)
    ) u_pch (
        .mclk   (mclk),
        .rst_n  (rst_n),
        .pins   (pinChangeInputs[11:PC_LOW_W]),
        .mask   (maskHi_q[PC_HIGH_W-1:0]),
        .clr    (takePch),
        .change (pchChange),
        .flag   (pchFlag)
    );

    // ----------------------------------------
    // Wake path, works with I/O clock stopped
    // ----------------------------------------
    assign wakeReq = (ctrl_q.extEn & levelMode & ~extIrqPin)
                   | (ctrl_q.pcLowEn & pclChange)
                   | (ctrl_q.pcHighEn & pchChange);

    // ----------------------------------------
    // Reset vector pending
    // ----------------------------------------
    logic resetPend_q;
    logic resetPend_d;
    logic takeReset;

    assign takeReset = vecTaken & vecValid & (vecAddr == `EIRQ_VEC_RESET);

    always_comb begin
        resetPend_d = (|resetCause) | (resetPend_q & ~takeReset);
    end

    // Leaving reset always starts at the reset vector
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            resetPend_q <= 1'b1;
        end else begin
            resetPend_q <= resetPend_d;
        end
    end

    // ----------------------------------------
    // Request assembly and dispatch
    // ----------------------------------------
    logic [NVEC-1:0] reqVec;
    logic [4:0]      winIdx;
    logic            winValid;
    logic            vecValid_q;
    logic            vecValid_d;
    logic [4:0]      vecAddr_q;
    logic [4:0]      vecAddr_d;

    always_comb begin
        reqVec = '0;
        reqVec[`EIRQ_VEC_RESET] = resetPend_q;
        reqVec[`EIRQ_VEC_EXT]   = extReq & ctrl_q.extEn & globalIntEn;
        reqVec[`EIRQ_VEC_PCL]   = pclFlag & ctrl_q.pcLowEn & globalIntEn;
        reqVec[`EIRQ_VEC_PCH]   = pchFlag & ctrl_q.pcHighEn & globalIntEn;
        reqVec[NVEC-1:4]        = periphReq & {N_PERIPH{globalIntEn}};
    end

    eirq_prio #(
        .N (NVEC)
    ) u_prio (
        .req   (reqVec),
        .idx   (winIdx),
        .valid (winValid)
    );

    always_comb begin
        // Vector address equals table index
        vecAddr_d  = winIdx;
        // Nothing pending gives no fetch; drop one cycle after a take
        vecValid_d = winValid & ~(vecTaken & vecValid_q);
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            vecValid_q <= 1'b0;
            vecAddr_q  <= `EIRQ_VEC_RESET;
        end else begin
            vecValid_q <= vecValid_d;
            vecAddr_q  <= vecAddr_d;
        end
    end

    assign vecValid = vecValid_q;
    assign vecAddr  = vecAddr_q;

    // ----------------------------------------
    // Acknowledge to peripheral sources
    // ----------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < N_PERIPH; gi++) begin : g_pack
            assign periphAck[gi] = vecTaken & vecValid_q
                                 & (vecAddr_q == `EIRQ_VEC_PERIPH + 5'(gi));
        end
    endgenerate

    // ----------------------------------------
    // Bus answer and read data
    // ----------------------------------------
    always_comb begin
        ack_d  = busHit;
        rdat_d = rdat_q;
        if (busHit) begin
            rdat_d = 32'h0000_0000;
            if (regHit(wbReq.adr, `EIRQ_ADR_CTRL)) begin
                rdat_d[4:0] = ctrl_q;
            end
            if (regHit(wbReq.adr, `EIRQ_ADR_FLAG)) begin
                rdat_d[`EIRQ_FLG_EXT] = extFlag_q;
                rdat_d[`EIRQ_FLG_PCL] = pclFlag;
                rdat_d[`EIRQ_FLG_PCH] = pchFlag;
            end
            if (regHit(wbReq.adr, `EIRQ_ADR_MASK_LO)) begin
                rdat_d[7:0] = maskLo_q;
            end
            if (regHit(wbReq.adr, `EIRQ_ADR_MASK_HI)) begin
                rdat_d[7:0] = maskHi_q;
            end
            if (regHit(wbReq.adr, `EIRQ_ADR_STATUS)) begin
                rdat_d[4:0]            = vecAddr_q;
                rdat_d[`EIRQ_ST_VALID] = vecValid_q;
                rdat_d[`EIRQ_ST_PIN]   = pinSamp_q;
                rdat_d[`EIRQ_ST_WAKE]  = wakeReq;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ack_q  <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end else begin
            ack_q  <= ack_d;
            rdat_q <= rdat_d;
        end
    end
endmodule : eirq_top

// ---- dv/eirq_top_properties.sv ----
`timescale 1ns/1ps
module eirq_top_properties #(
    parameter int N_PERIPH = 13
) (
    input wire logic                mclk,
    input wire logic                rst_n,
    input wire logic                wb_cyc_i,
    input wire logic                wb_stb_i,
    input wire logic                wb_we_i,
    input wire logic [7:0]          wb_adr_i,
    input wire logic [3:0]          wb_sel_i,
    input wire logic [31:0]         wb_dat_i,
    input wire logic                wb_ack_o,
    input wire logic                extIrqPin,
    input wire logic                globalIntEn,
    input wire logic [3:0]          resetCause,
    input wire logic                vecTaken,
    input wire logic                vecValid,
    input wire logic [4:0]          vecAddr,
    input wire logic [N_PERIPH-1:0] periphAck,
    input wire logic                wakeReq
);
    logic [4:0] shadowCtrl_q;
    logic       lvlLow;
    logic       took;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    // ----------------------------------------
    // Control register shadow
    // ----------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            shadowCtrl_q <= 5'h00;
        end else if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0]
                     && wb_adr_i == 8'h00) begin
            shadowCtrl_q <= wb_dat_i[4:0];
        end
    end
    assign lvlLow = shadowCtrl_q[2] && shadowCtrl_q[1:0] == 2'h0 && !extIrqPin;
    assign took   = vecTaken && vecValid;

    AST_VEC_RANGE: assert property (vecValid |-> vecAddr <= 5'h10)
        else $error("vector address beyond table");
    AST_RESET_VEC: assert property (resetCause != 4'h0 |-> ##[1:4] (vecValid && vecAddr == 5'h00))
        else $error("reset cause not dispatched to address zero");
    AST_PERIPH_ACK: assert property (took && vecAddr >= 5'h04 |->
        periphAck == N_PERIPH'(1) << (vecAddr - 5'h04))
        else $error("wrong peripheral acknowledged");
    AST_NO_SPURIOUS: assert property (!took || vecAddr < 5'h04 |-> periphAck == '0)
        else $error("peripheral acknowledged without a take");
    AST_LEVEL_REQ: assert property ((lvlLow && globalIntEn)[*3] ##0
        (!$past(vecTaken) && !$past(vecTaken, 2)) |-> vecValid && vecAddr <= 5'h01)
        else $error("held low level not requesting");
    AST_WAKE_LEVEL: assert property (lvlLow |-> wakeReq)
        else $error("low level gives no wake");
    AST_TAKE_CLEARS: assert property (took |=> !vecValid)
        else $error("vector still offered after take");
    AST_GLOBAL_GATE: assert property (vecValid && vecAddr != 5'h00 |-> $past(globalIntEn))
        else $error("vector offered with global enable off");
    AST_WB_ACK: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus answer not a single cycle");

    cover property (took && vecAddr == 5'h01);
    cover property (took && vecAddr == 5'h02);
    cover property (took && vecAddr == 5'h03);
endmodule : eirq_top_properties

bind eirq_top eirq_top_properties #(.N_PERIPH(N_PERIPH)) u_props (
    .mclk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_ack_o, .extIrqPin, .globalIntEn, .resetCause, .vecTaken, .vecValid,
    .vecAddr, .periphAck, .wakeReq
);

// ---- dv/eirq_core_model.sv ----
`timescale 1ns/1ps
module eirq_core_model (
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire logic       vecValid,
    input  wire logic [3:0] lag,
    output logic            vecTaken
);
    // Takes an offered vector lag+1 cycles after it appears; 4'hF holds off
    logic [3:0] waitCnt_q;
    logic [3:0] waitCnt_d;
    logic       take_d;

    always_comb begin
        take_d    = 1'b0;
        waitCnt_d = 4'h0;
        if (vecValid && !vecTaken && lag != 4'hF) begin
            if (waitCnt_q >= lag) begin
                take_d = 1'b1;
            end else begin
                waitCnt_d = waitCnt_q + 4'h1;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            waitCnt_q <= 4'h0;
            vecTaken  <= 1'b0;
        end else begin
            waitCnt_q <= waitCnt_d;
            vecTaken  <= take_d;
        end
    end
endmodule : eirq_core_model

// ---- dv/external_irq_and_vector_map_tb.sv ----
`timescale 1ns/1ps
module external_irq_and_vector_map_tb;
    logic        mclk = 1'b0;
    logic        rst_n = 1'b0;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [3:0]  wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        extIrqPin = 1'b1;
    logic [11:0] pinChangeInputs = 12'h000;
    logic        ioClkEn = 1'b1;
    logic        globalIntEn = 1'b0;
    logic [3:0]  resetCause = 4'h0;
    logic [12:0] periphReq = 13'h0000;
    logic [12:0] periphSet = 13'h0000;
    logic [12:0] periphAck;
    logic        vecTaken;
    logic        vecValid;
    logic        wakeReq;
    logic [4:0]  vecAddr;
    logic [3:0]  lag = 4'hF;
    logic [12:0] m;
    logic [11:0] mAll;
    logic [31:0] expVec[$];
    logic [31:0] expRd[$];
    int          fail_count = 0;
    int          checked = 0;

    always #5 mclk = ~mclk;

    eirq_top u_dut (
        .mclk(mclk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .extIrqPin(extIrqPin),
        .pinChangeInputs(pinChangeInputs), .ioClkEn(ioClkEn), .globalIntEn(globalIntEn),
        .resetCause(resetCause), .periphReq(periphReq), .vecTaken(vecTaken),
        .vecValid(vecValid), .vecAddr(vecAddr), .periphAck(periphAck), .wakeReq(wakeReq)
    );

    eirq_core_model u_core (
        .mclk(mclk), .rst_n(rst_n), .vecValid(vecValid), .lag(lag), .vecTaken(vecTaken)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic tally_and_finish();
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : tally_and_finish

    // ----------------------------------------
    // Result watcher and peripheral request holders
    // ----------------------------------------
    always @(posedge mclk) begin
        periphReq <= (periphReq & ~periphAck) | periphSet;
        if (rst_n && vecTaken === 1'b1 && vecValid === 1'b1)
            check({27'h0, vecAddr}, expVec.size() ? expVec.pop_front() : 32'hFFFF);
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
            check(wb_dat_o, expRd.size() ? expRd.pop_front() : 32'hFFFF);
    end

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask : tick

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        if (!w) expRd.push_back(d);
        @(posedge mclk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_adr_i <= a;
        wb_dat_i <= w ? d : 32'h0;
        do begin
            @(posedge mclk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (n >= 20) begin
            fail_count++;
            tally_and_finish();
        end
    endtask : bus

    task automatic drain();
        int n = 0;
        while (expVec.size() != 0 && n < 400) begin
            @(posedge mclk);
            n++;
        end
        if (n >= 400) begin
            fail_count++;
            tally_and_finish();
        end
    endtask : drain

    initial begin
        void'($urandom(32'hD387));
        expVec.push_back(32'h0);
        tick(4);
        rst_n <= 1'b1;
        lag <= 4'h0;
        drain();
        bus(1'b0, 8'h00, 32'h0);
        bus(1'b0, 8'h0C, 32'h0);
        bus(1'b1, 8'h40, 32'hFF);
        bus(1'b0, 8'h40, 32'h0);
        // Pending peripherals leave lowest first, only with global enable
        for (int r = 0; r < 6; r++) begin
            m = (r == 0) ? 13'h1FFF : 13'($urandom_range(8191, 1));
            for (int i = 0; i < 13; i++) if (m[i]) expVec.push_back(32'(i + 4));
            lag <= 4'($urandom_range(3, 0));
            globalIntEn <= 1'b0;
            periphSet <= m;
            tick(1);
            periphSet <= 13'h0000;
            tick(8);
            check({31'h0, vecValid}, 32'h0);
            globalIntEn <= 1'b1;
            drain();
        end
        resetCause <= 4'($urandom_range(15, 1));
        expVec.push_back(32'h0);
        tick(1);
        resetCause <= 4'h0;
        drain();
        // External pin in change, fall and rise modes
        for (int s = 1; s < 4; s++) begin
            bus(1'b1, 8'h00, 32'(4 + s));
            repeat ((s == 1) ? 2 : 1) expVec.push_back(32'h1);
            extIrqPin <= 1'b0;
            tick((s == 1) ? 10 : 2);
            extIrqPin <= 1'b1;
            tick(10);
            drain();
        end
        ioClkEn <= 1'b0;
        bus(1'b1, 8'h00, 32'h06);
        extIrqPin <= 1'b0;
        tick(5);
        extIrqPin <= 1'b1;
        tick(5);
        ioClkEn <= 1'b1;
        tick(10);
        // Low level, released before the core takes it
        lag <= 4'hF;
        bus(1'b1, 8'h00, 32'h04);
        ioClkEn <= 1'b0;
        extIrqPin <= 1'b0;
        tick(6);
        check({31'h0, wakeReq}, 32'h1);
        check({27'h0, vecAddr}, 32'h1);
        bus(1'b0, 8'h04, 32'h0);
        bus(1'b0, 8'h10, 32'hE1);
        extIrqPin <= 1'b1;
        tick(4);
        check({31'h0, vecValid}, 32'h0);
        // Pin-change groups with the I/O clock stopped
        m = 13'($urandom);
        mAll = {m[3:0], m[11:5], 1'b1};
        bus(1'b1, 8'h08, {24'h0, mAll[7:0]});
        bus(1'b1, 8'h0C, {24'h0, 4'hF, mAll[11:8]});
        bus(1'b0, 8'h08, {24'h0, mAll[7:0]});
        bus(1'b0, 8'h0C, {28'h0, mAll[11:8]});
        bus(1'b1, 8'h00, 32'h18);
        lag <= 4'($urandom_range(3, 0));
        for (int j = 0; j < 12; j++) begin
            if (mAll[j]) expVec.push_back((j < 8) ? 32'h2 : 32'h3);
            pinChangeInputs[j] <= ~pinChangeInputs[j];
            tick(1);
            check({31'h0, wakeReq}, {31'h0, mAll[j]});
            tick(9);
        end
        drain();
        lag <= 4'hF;
        pinChangeInputs[0] <= ~pinChangeInputs[0];
        tick(4);
        bus(1'b0, 8'h04, 32'h2);
        bus(1'b1, 8'h04, 32'h2);
        bus(1'b0, 8'h04, 32'h0);
        tick(3);
        check({31'h0, vecValid}, 32'h0);
        ioClkEn <= 1'b1;
        tally_and_finish();
    end
endmodule : external_irq_and_vector_map_tb
